/* inc/gmcg_pkg.sv */
// constants for the pin mode and converter gating block
// assumes a 32-bit classic wishbone slave port, byte addresses
package gmcg_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] GMCG_OFS_PINS12   = 8'h00;
  localparam logic [7:0] GMCG_OFS_PIN3     = 8'h04;
  localparam logic [7:0] GMCG_OFS_CONV     = 8'h08;
  localparam logic [7:0] GMCG_OFS_HOSTCMD  = 8'h0C;
  localparam logic [7:0] GMCG_OFS_STATE    = 8'h10;
  localparam logic [7:0] GMCG_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] GMCG_OFS_IRQ_MASK = 8'h18;

  // ----------------------------------------------------------------
  // pins_one_two_ctrl fields
  // ----------------------------------------------------------------
  localparam int GMCG_B_PIN2_DIR  = 7;
  localparam int GMCG_B_PIN1_DIR  = 6;
  localparam int GMCG_B_PIN2_OUT  = 5;
  localparam int GMCG_B_PIN1_OUT  = 4;
  localparam int GMCG_B_PIN2_POL  = 3;
  localparam int GMCG_B_PIN1_POL  = 2;
  localparam int GMCG_B_PIN1_SBY  = 1;
  localparam int GMCG_B_PIN1_BUCK = 0;

  // ----------------------------------------------------------------
  // pin3 / function register fields
  // ----------------------------------------------------------------
  localparam int GMCG_B_PIN3_DIR  = 7;
  localparam int GMCG_B_PIN3_OUT  = 6;
  localparam int GMCG_B_PIN2_IRQ  = 2;
  localparam int GMCG_B_PIN1_IRQ  = 1;
  localparam int GMCG_B_PIN2_BUCK = 0;

  // conversion trigger register fields
  localparam int GMCG_B_TRIG_EN   = 0;
  localparam int GMCG_B_TRIG_EDGE = 1;

  // host command register fields
  localparam int GMCG_B_HOST_A    = 0;
  localparam int GMCG_B_HOST_B    = 1;
  localparam int GMCG_B_HOST_SBY  = 2;

  // event bits of status and mask
  localparam int GMCG_B_EV_PIN1   = 0;
  localparam int GMCG_B_EV_PIN2   = 1;
  localparam int GMCG_B_EV_CONV   = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GMCG_RST_PINS12  = 8'h00;
  localparam logic [7:0] GMCG_RST_PIN3    = 8'h00;
  localparam logic [1:0] GMCG_RST_CONV    = 2'h0;
  localparam logic [2:0] GMCG_RST_HOSTCMD = 3'h0;
  localparam logic [2:0] GMCG_RST_MASK    = 3'h0;

endpackage

/* hdl/gmcg_top.sv */
// pin mode, interrupt and converter gating logic for three open-drain pins
// assumes a classic wishbone master and pin inputs asynchronous to ref_clk
//
// What this block does
// [RULE1] converter runs only if host enables and, when its pin is set to gate it, that pin enables
// [RULE2] standby only when host asks and, if pin one is set to standby, pin one asks too
// [RULE3] pin three output: one floats, zero drives low
// [RULE4] pin three input edge starts a conversion
// [RULE5] pin two output: one floats, zero pulls low
// [RULE6] pin one output: one floats, zero pulls low
// [RULE7] pin two edge asserts interrupt line low
// [RULE8] pin one edge asserts interrupt line low
// [RULE9] polarity zero selects rising edge
// [RULE10] pin two level requests converter b on
// [RULE11] pin one level requests converter a on
// [RULE12] pin one level requests standby for both
// [RULE13] host sets one function bit per input
// [RULE14] interrupt held until second edge and read
// [RULE15] mask register gates pin interrupt requests
// [RULE16] all pins start as inputs, no function
// [RULE17] pin inputs synchronised before any use
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps

module gmcg_top
  import gmcg_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [2:0]  pin_i,
  output logic      [2:0]  pin_o,
  output logic      [2:0]  pin_oe_n,
  output logic             buck_a_en,
  output logic             buck_b_en,
  output logic             buck_standby,
  output logic             conv_start,
  output logic             int_n,
  output logic             irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic sel_edge(input logic rise, input logic fall, input logic pol);
    sel_edge = pol ? fall : rise; // see [RULE9]
  endfunction

  function automatic logic level_match(input logic lvl, input logic pol);
    level_match = (lvl == pol);
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [7:0] pins12;
  logic [7:0] pin3_reg;
  logic [1:0] conv_reg;
  logic [2:0] host_cmd;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [1:0] int_hold;
  logic       hold_p1;
  logic       hold_p2;
  logic       second_p1;
  logic       second_p2;

  logic       wb_req;
  logic       wr_en;
  logic       rd_en;
  logic       rd_stat;
  logic [2:0] rise;
  logic [2:0] fall;
  logic       p1_in;
  logic       p2_in;
  logic       p3_in;
  logic       p1_irq_mode;
  logic       p2_irq_mode;
  logic       p1_buck_mode;
  logic       p2_buck_mode;
  logic       p1_sby_mode;
  logic       trig_mode;
  logic [1:0] irq_edge;
  logic [1:0] any_edge;
  logic       trig_edge;
  logic [2:0] ev;
  logic       pin_a_req;
  logic       pin_b_req;
  logic       pin_sby_req;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en   = wb_req & wb_we_i & wb_sel_i[0];
  assign rd_en   = wb_req & ~wb_we_i;
  assign rd_stat = rd_en & (wb_adr_i == GMCG_OFS_IRQ_STAT);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (wb_adr_i == GMCG_OFS_PINS12) begin
      next_rdata[7:0] = pins12;
    end else if (wb_adr_i == GMCG_OFS_PIN3) begin
      next_rdata[7:0] = pin3_reg;
    end else if (wb_adr_i == GMCG_OFS_CONV) begin
      next_rdata[1:0] = conv_reg;
    end else if (wb_adr_i == GMCG_OFS_HOSTCMD) begin
      next_rdata[2:0] = host_cmd;
    end else if (wb_adr_i == GMCG_OFS_STATE) begin
      next_rdata[0]   = buck_a_en;
      next_rdata[1]   = buck_b_en;
      next_rdata[2]   = buck_standby;
      next_rdata[5:3] = sync2;
      next_rdata[6]   = ~int_n;
    end else if (wb_adr_i == GMCG_OFS_IRQ_STAT) begin
      next_rdata[2:0] = irq_stat;
    end else if (wb_adr_i == GMCG_OFS_IRQ_MASK) begin
      next_rdata[2:0] = irq_mask;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_en) begin
      wb_dat_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pins12   <= GMCG_RST_PINS12; // see [RULE16]
      pin3_reg <= GMCG_RST_PIN3; // see [RULE16]
      conv_reg <= GMCG_RST_CONV;
      host_cmd <= GMCG_RST_HOSTCMD;
      irq_mask <= GMCG_RST_MASK;
    end else if (wr_en) begin
      if (wb_adr_i == GMCG_OFS_PINS12) begin
        pins12 <= wb_dat_i[7:0];
      end else if (wb_adr_i == GMCG_OFS_PIN3) begin
        pin3_reg <= {wb_dat_i[7:6], 3'h0, wb_dat_i[2:0]};
      end else if (wb_adr_i == GMCG_OFS_CONV) begin
        conv_reg <= wb_dat_i[1:0];
      end else if (wb_adr_i == GMCG_OFS_HOSTCMD) begin
        host_cmd <= wb_dat_i[2:0];
      end else if (wb_adr_i == GMCG_OFS_IRQ_MASK) begin
        irq_mask <= wb_dat_i[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin input synchronisers and edges
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      sync3 <= 3'h7;
    end else begin
      sync1 <= pin_i; // see [RULE17]
      sync2 <= sync1; // see [RULE17]
      sync3 <= sync2;
    end
  end

  assign rise  = sync2 & ~sync3;
  assign fall  = ~sync2 & sync3;
  assign p1_in = ~pins12[GMCG_B_PIN1_DIR];
  assign p2_in = ~pins12[GMCG_B_PIN2_DIR];
  assign p3_in = ~pin3_reg[GMCG_B_PIN3_DIR];

  // ----------------------------------------------------------------
  // function decode
  // ----------------------------------------------------------------
  assign p1_irq_mode  = p1_in & pin3_reg[GMCG_B_PIN1_IRQ] & ~pins12[GMCG_B_PIN1_BUCK]
                        & ~pins12[GMCG_B_PIN1_SBY]; // see [RULE8]
  assign p2_irq_mode  = p2_in & pin3_reg[GMCG_B_PIN2_IRQ] & ~pin3_reg[GMCG_B_PIN2_BUCK]; // see [RULE7]
  assign p1_buck_mode = p1_in & ~pin3_reg[GMCG_B_PIN1_IRQ] & pins12[GMCG_B_PIN1_BUCK]
                        & ~pins12[GMCG_B_PIN1_SBY]; // see [RULE11]
  assign p2_buck_mode = p2_in & ~pin3_reg[GMCG_B_PIN2_IRQ] & pin3_reg[GMCG_B_PIN2_BUCK]; // see [RULE10]
  assign p1_sby_mode  = p1_in & ~pin3_reg[GMCG_B_PIN1_IRQ] & ~pins12[GMCG_B_PIN1_BUCK]
                        & pins12[GMCG_B_PIN1_SBY]; // see [RULE12]
  assign trig_mode    = p3_in & conv_reg[GMCG_B_TRIG_EN];

  assign irq_edge[0] = p1_irq_mode & sel_edge(rise[0], fall[0], pins12[GMCG_B_PIN1_POL]); // see [RULE8]
  assign irq_edge[1] = p2_irq_mode & sel_edge(rise[1], fall[1], pins12[GMCG_B_PIN2_POL]); // see [RULE7]
  assign any_edge    = rise[1:0] | fall[1:0];
  assign trig_edge   = trig_mode & sel_edge(rise[2], fall[2], ~conv_reg[GMCG_B_TRIG_EDGE]); // see [RULE4]
  assign ev          = {trig_edge, irq_edge};

  // ----------------------------------------------------------------
  // held interrupt line, pin one
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hold_p1   <= 1'b0;
      second_p1 <= 1'b0;
    end else if (!p1_irq_mode) begin
      hold_p1   <= 1'b0; // see [RULE14]
      second_p1 <= 1'b0;
    end else if (!hold_p1) begin
      hold_p1   <= irq_edge[0];
      second_p1 <= 1'b0;
    end else if (second_p1 && rd_stat) begin
      hold_p1   <= 1'b0; // see [RULE14]
      second_p1 <= 1'b0;
    end else if (any_edge[0]) begin
      second_p1 <= 1'b1; // see [RULE14]
    end
  end

  // ----------------------------------------------------------------
  // held interrupt line, pin two
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hold_p2   <= 1'b0;
      second_p2 <= 1'b0;
    end else if (!p2_irq_mode) begin
      hold_p2   <= 1'b0; // see [RULE14]
      second_p2 <= 1'b0;
    end else if (!hold_p2) begin
      hold_p2   <= irq_edge[1];
      second_p2 <= 1'b0;
    end else if (second_p2 && rd_stat) begin
      hold_p2   <= 1'b0; // see [RULE14]
      second_p2 <= 1'b0;
    end else if (any_edge[1]) begin
      second_p2 <= 1'b1; // see [RULE14]
    end
  end

  assign int_hold = {hold_p2, hold_p1};

  // ----------------------------------------------------------------
  // sticky event status, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= 3'h0;
    end else if (wr_en && wb_adr_i == GMCG_OFS_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~wb_dat_i[2:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end

  // ----------------------------------------------------------------
  // interrupt outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~|(int_hold & irq_mask[1:0]); // see [RULE15]
    end
  end

  // ----------------------------------------------------------------
  // conversion trigger pulse
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= trig_edge; // see [RULE4]
    end
  end

  // ----------------------------------------------------------------
  // open-drain pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_o <= 3'h0;
    end else begin
      pin_o <= 3'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_oe_n <= 3'h7;
    end else begin
      pin_oe_n[0] <= ~(pins12[GMCG_B_PIN1_DIR] & ~pins12[GMCG_B_PIN1_OUT]); // see [RULE6]
      pin_oe_n[1] <= ~(pins12[GMCG_B_PIN2_DIR] & ~pins12[GMCG_B_PIN2_OUT]); // see [RULE5]
      pin_oe_n[2] <= ~(pin3_reg[GMCG_B_PIN3_DIR] & ~pin3_reg[GMCG_B_PIN3_OUT]); // see [RULE3]
    end
  end

  // ----------------------------------------------------------------
  // converter gating
  // ----------------------------------------------------------------
  assign pin_a_req   = p1_buck_mode ? level_match(sync2[0], pins12[GMCG_B_PIN1_POL]) : 1'b1; // see [RULE11]
  assign pin_b_req   = p2_buck_mode ? level_match(sync2[1], pins12[GMCG_B_PIN2_POL]) : 1'b1; // see [RULE10]
  assign pin_sby_req = p1_sby_mode ? level_match(sync2[0], pins12[GMCG_B_PIN1_POL]) : 1'b1; // see [RULE12]

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      buck_a_en <= 1'b0;
    end else begin
      buck_a_en <= host_cmd[GMCG_B_HOST_A] & pin_a_req; // see [RULE1]
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      buck_b_en <= 1'b0;
    end else begin
      buck_b_en <= host_cmd[GMCG_B_HOST_B] & pin_b_req; // see [RULE1]
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      buck_standby <= 1'b0;
    end else begin
      buck_standby <= host_cmd[GMCG_B_HOST_SBY] & pin_sby_req; // see [RULE2]
    end
  end

endmodule // gmcg_top

/* tb/gmcg_pin_world.sv */
// external drivers on the three open-drain pins
// assumes pull-ups on every pin and bench-chosen driver levels
`timescale 1ns/100ps

module gmcg_pin_world (
  input  wire logic [2:0] ext_drv,
  input  wire logic [2:0] pin_oe_n,
  output logic      [2:0] pin_lvl
);
  // wired-and: either side may pull low, pull-up otherwise
  assign pin_lvl = ext_drv & pin_oe_n;
endmodule // gmcg_pin_world

/* tb/gmcg_monitor.sv */
// concurrent checks on the ports of gmcg_top
// assumes one ref_clk domain and nrst active low
`timescale 1ns/100ps

module gmcg_monitor
  import gmcg_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [2:0]  pin_i,
  input wire logic [2:0]  pin_o,
  input wire logic [2:0]  pin_oe_n,
  input wire logic        buck_a_en,
  input wire logic        buck_b_en,
  input wire logic        buck_standby,
  input wire logic        conv_start,
  input wire logic        int_n,
  input wire logic        irq
);
  // ----------------------------------------------------------------
  // write taken with masked data
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_wr(logic [7:0] a, logic [7:0] m, logic [7:0] v);
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == a && (wb_dat_i[7:0] & m) == v;
  endsequence
  chk_drive_low_only: assert property (pin_o == 3'h0)
    else $error("pin output not low");
  chk_reset_state: assert property ($rose(nrst) |-> pin_oe_n == 3'h7 && int_n && !buck_a_en && !buck_b_en)
    else $error("bad state after reset");
  chk_host_a_off: assert property (s_wr(GMCG_OFS_HOSTCMD, 8'h01, 8'h00) |=> ##[0:1] !buck_a_en)
    else $error("converter a not off");
  chk_host_b_off: assert property (s_wr(GMCG_OFS_HOSTCMD, 8'h02, 8'h00) |=> ##[0:1] !buck_b_en)
    else $error("converter b not off");
  chk_host_sby_off: assert property (s_wr(GMCG_OFS_HOSTCMD, 8'h04, 8'h00) |=> ##[0:1] !buck_standby)
    else $error("standby not left");
  chk_pin1_drive: assert property (s_wr(GMCG_OFS_PINS12, 8'h50, 8'h40) |=> ##[0:1] !pin_oe_n[0])
    else $error("pin one not driven");
  chk_pin2_drive: assert property (s_wr(GMCG_OFS_PINS12, 8'hA0, 8'h80) |=> ##[0:1] !pin_oe_n[1])
    else $error("pin two not driven");
  chk_pin3_drive: assert property (s_wr(GMCG_OFS_PIN3, 8'hC0, 8'h80) |=> ##[0:1] !pin_oe_n[2])
    else $error("pin three not driven");
  chk_conv_pulse: assert property (conv_start |=> !conv_start)
    else $error("trigger pulse too long");
  chk_int_release: assert property ($rose(int_n) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("interrupt released without access");
endmodule // gmcg_monitor

bind gmcg_top gmcg_monitor gmcg_monitor_inst (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
  .buck_a_en(buck_a_en), .buck_b_en(buck_b_en), .buck_standby(buck_standby), .conv_start(conv_start),
  .int_n(int_n), .irq(irq));

/* tb/gmcg_top_bench.sv */
// self-checking bench for gmcg_top
// assumes the pin world model and the bound port checker
`timescale 1ns/100ps

module gmcg_top_bench
  import gmcg_pkg::*;
;
  logic        ref_clk, nrst, cyc, stb, we;
  logic [7:0]  adr, q;
  logic [31:0] dat, wb_dat_o;
  logic [2:0]  ext, pin_lvl, pin_o, pin_oe_n;
  logic        wb_ack_o, buck_a_en, buck_b_en, buck_standby, conv_start, int_n, irq;
  logic [15:0] rnd;
  int          failures, comparisons, cycles, n, h, pol, l, p, mk;

  gmcg_top gmcg_top_inst (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .buck_a_en(buck_a_en), .buck_b_en(buck_b_en),
    .buck_standby(buck_standby), .conv_start(conv_start), .int_n(int_n), .irq(irq));
  gmcg_pin_world gmcg_pin_world_inst (.ext_drv(ext), .pin_oe_n(pin_oe_n), .pin_lvl(pin_lvl));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function logic gate(input logic hc, input logic pc, input logic lv);
    return hc & (lv == pc);
  endfunction
  task end_sim;
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task wait_c(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task pulses;
    n = 0;
    repeat (8) begin
      @(negedge ref_clk);
      if (conv_start === 1'b1) n++;
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_sim;
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0; ext = 3'h7; rnd = 16'hC320;
    wait_c(10);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) if (i != 4) begin
      wb(1'b0, 8'(i * 4), 8'h00);
      chk(q, 8'h00);
    end
    chk({4'h0, int_n, pin_oe_n}, 8'h0F);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      wb(1'b1, GMCG_OFS_PINS12, {2'b11, rnd[1:0], 4'h0});
      wb(1'b1, GMCG_OFS_PIN3, {1'b1, rnd[2], 6'h0});
      wait_c(2);
      chk({5'h0, pin_oe_n}, {5'h0, rnd[2:0]});
      wb(1'b0, GMCG_OFS_PINS12, 8'h00);
      chk(q, {2'b11, rnd[1:0], 4'h0});
    end
    wb(1'b1, GMCG_OFS_PIN3, 8'h00);
    for (int m = 0; m < 3; m++) for (int i = 0; i < 8; i++) begin
      h = i & 1; pol = (i >> 1) & 1; l = (i >> 2) & 1;
      @(posedge ref_clk) ext[m == 1] <= l[0];
      wb(1'b1, GMCG_OFS_PINS12, m == 1 ? 8'(pol << 3) : 8'((pol << 2) | (m == 2 ? 2 : 1)));
      wb(1'b1, GMCG_OFS_PIN3, m == 1 ? 8'h01 : 8'h00);
      wb(1'b1, GMCG_OFS_HOSTCMD, 8'(h << m));
      wait_c(5);
      chk({7'h0, m == 0 ? buck_a_en : m == 1 ? buck_b_en : buck_standby}, {7'h0, gate(h[0], pol[0], l[0])});
    end
    wb(1'b1, GMCG_OFS_HOSTCMD, 8'h00);
    for (int k = 0; k < 8; k++) begin
      p = k & 1; pol = (k >> 1) & 1; mk = (k >> 2) & 1;
      @(posedge ref_clk) ext <= 3'h7 & ~(3'(!pol[0]) << p);
      wait_c(4);
      wb(1'b1, GMCG_OFS_IRQ_MASK, 8'(mk << p));
      wb(1'b1, GMCG_OFS_PINS12, 8'(pol << (2 + p)));
      wb(1'b1, GMCG_OFS_PIN3, 8'(2 << p));
      @(posedge ref_clk) ext[p] <= ~pol[0];
      wait_c(6);
      chk({6'h0, irq, int_n}, {6'h0, mk[0], ~mk[0]});
      wb(1'b0, GMCG_OFS_IRQ_STAT, 8'h00);
      chk(q, 8'(1 << p));
      wait_c(4);
      chk({7'h0, int_n}, {7'h0, ~mk[0]});
      @(posedge ref_clk) ext[p] <= pol[0];
      wait_c(6);
      wb(1'b0, GMCG_OFS_IRQ_STAT, 8'h00);
      wait_c(4);
      chk({7'h0, int_n}, 8'h01);
      wb(1'b1, GMCG_OFS_IRQ_STAT, 8'h07);
      wb(1'b1, GMCG_OFS_PIN3, 8'h00);
      wait_c(2);
      chk({7'h0, irq}, 8'h00);
    end
    for (int e = 0; e < 2; e++) begin
      @(posedge ref_clk) ext[2] <= ~e[0];
      wait_c(4);
      wb(1'b1, GMCG_OFS_IRQ_MASK, 8'h04);
      wb(1'b1, GMCG_OFS_CONV, 8'(2 * e + 1));
      @(posedge ref_clk) ext[2] <= e[0];
      pulses;
      chk(8'(n), 8'h01);
      chk({7'h0, irq}, 8'h01);
      @(posedge ref_clk) ext[2] <= ~e[0];
      pulses;
      chk(8'(n), 8'h00);
      wb(1'b1, GMCG_OFS_IRQ_STAT, 8'h04);
      wb(1'b1, GMCG_OFS_CONV, 8'h00);
    end
    end_sim;
  end
endmodule // gmcg_top_bench
